// ---- csw_pkg.sv ----
// card status word: bit positions, flag indexes and state codes
package csw_pkg;

  // ----------------------------------------------------------------
  // word geometry
  // ----------------------------------------------------------------
  localparam int WORD_W  = 32;
  localparam int STATE_W = 4;
  localparam int STICKY_N = 16;
  localparam int LATE_N   = 2;

  // ----------------------------------------------------------------
  // bit positions in the status word
  // ----------------------------------------------------------------
  localparam int POS_ARG_RANGE    = 31;
  localparam int POS_MISALIGN     = 30;
  localparam int POS_BLK_LENGTH   = 29;
  localparam int POS_ERASE_ORDER  = 28;
  localparam int POS_ERASE_SELECT = 27;
  localparam int POS_PROT_WRITE   = 26;
  localparam int POS_LOCKED       = 25;
  localparam int POS_LOCK_FAIL    = 24;
  localparam int POS_CMD_CHECK    = 23;
  localparam int POS_ILLEGAL      = 22;
  localparam int POS_ECC_FAIL     = 21;
  localparam int POS_CONTROLLER   = 20;
  localparam int POS_GENERAL      = 19;
  localparam int POS_UNDERRUN     = 18;
  localparam int POS_OVERRUN      = 17;
  localparam int POS_REWRITE      = 16;
  localparam int POS_ERASE_SKIP   = 15;
  localparam int POS_ECC_OFF      = 14;
  localparam int POS_ERASE_ABORT  = 13;
  localparam int POS_STATE_LO     = 9;
  localparam int POS_BUF_EMPTY    = 8;
  localparam int POS_APP_EXPECT   = 5;

  // lowest error bit; the error summary covers from here to the top, the lock state bit 25 included
  localparam int POS_ERR_LO       = 16;

  // ----------------------------------------------------------------
  // indexes into the clear-on-read flag vector
  // ----------------------------------------------------------------
  localparam int C_ARG_RANGE    = 0;
  localparam int C_MISALIGN     = 1;
  localparam int C_BLK_LENGTH   = 2;
  localparam int C_ERASE_ORDER  = 3;
  localparam int C_ERASE_SELECT = 4;
  localparam int C_PROT_WRITE   = 5;
  localparam int C_LOCK_FAIL    = 6;
  localparam int C_ECC_FAIL     = 7;
  localparam int C_CONTROLLER   = 8;
  localparam int C_GENERAL      = 9;
  localparam int C_UNDERRUN     = 10;
  localparam int C_OVERRUN      = 11;
  localparam int C_REWRITE      = 12;
  localparam int C_ERASE_SKIP   = 13;
  localparam int C_ERASE_ABORT  = 14;
  localparam int C_APP_EXPECT   = 15;

  // word position of each clear-on-read flag, by index
  localparam int C_POS [STICKY_N] = '{
    POS_ARG_RANGE, POS_MISALIGN, POS_BLK_LENGTH, POS_ERASE_ORDER,
    POS_ERASE_SELECT, POS_PROT_WRITE, POS_LOCK_FAIL, POS_ECC_FAIL,
    POS_CONTROLLER, POS_GENERAL, POS_UNDERRUN, POS_OVERRUN,
    POS_REWRITE, POS_ERASE_SKIP, POS_ERASE_ABORT, POS_APP_EXPECT};

  // ----------------------------------------------------------------
  // indexes into the one-command-late flag vector
  // ----------------------------------------------------------------
  localparam int B_CMD_CHECK = 0;
  localparam int B_ILLEGAL   = 1;

  localparam int B_POS [LATE_N] = '{POS_CMD_CHECK, POS_ILLEGAL};

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // card state codes
  // ----------------------------------------------------------------
  typedef enum logic [STATE_W-1:0] {
    CSW_IDLE  = 4'b0000,
    CSW_READY = 4'b0001,
    CSW_IDENT = 4'b0010,
    CSW_STBY  = 4'b0011,
    CSW_TRAN  = 4'b0100,
    CSW_DATA  = 4'b0101,
    CSW_RCV   = 4'b0110,
    CSW_PRG   = 4'b0111,
    CSW_DIS   = 4'b1000
  } csw_state_e;

endpackage

// ---- csw_flag_if.sv ----
// carrier between the status word top and its flag keepers
`timescale 1ns/100ps
interface csw_flag_if;
  logic [csw_pkg::STICKY_N-1:0] stickySet;
  logic                         readClear;
  logic [csw_pkg::STICKY_N-1:0] stickyFlag;
  logic [csw_pkg::LATE_N-1:0]   lateSet;
  logic [csw_pkg::LATE_N-1:0]   lateSetSeen;
  logic                         cmdValid;
  logic [csw_pkg::LATE_N-1:0]   lateFlag;

  modport owner (
    output stickySet,
    output readClear,
    output lateSet,
    output lateSetSeen,
    output cmdValid,
    input  stickyFlag,
    input  lateFlag
  );

  modport sticky (
    input  stickySet,
    input  readClear,
    output stickyFlag
  );

  modport late (
    input  lateSet,
    input  lateSetSeen,
    input  cmdValid,
    output lateFlag
  );
endinterface

// ---- csw_sticky_bits.sv ----
// clear-on-read flags: set by events, cleared when the word is read
`timescale 1ns/100ps
module csw_sticky_bits (
  input wire logic clk_sys,
  input wire logic arst_n,
  csw_flag_if.sticky flags
);

  // ----------------------------------------------------------------
  // one flag per event
  // ----------------------------------------------------------------
  for (genvar i = 0; i < csw_pkg::STICKY_N; i++) begin : gFlag
    // R3: set beats read clear
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        flags.stickyFlag[i] <= 1'b0;
      end else if (flags.stickySet[i]) begin
        flags.stickyFlag[i] <= 1'b1;
      end else if (flags.readClear) begin
        flags.stickyFlag[i] <= 1'b0;
      end
    end
  end

endmodule

// ---- csw_late_bits.sv ----
// flags cleared by a later valid command: the first after the fault when lateSetSeen is set, else the second
`timescale 1ns/100ps
module csw_late_bits (
  input wire logic clk_sys,
  input wire logic arst_n,
  csw_flag_if.late flags
);

  logic [csw_pkg::LATE_N-1:0] armed;

  // ----------------------------------------------------------------
  // one flag with its arming bit per fault
  // ----------------------------------------------------------------
  for (genvar i = 0; i < csw_pkg::LATE_N; i++) begin : gLate
    // R2: clear one valid command late
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        flags.lateFlag[i] <= 1'b0;
        armed[i]          <= 1'b0;
      end else if (flags.lateSet[i]) begin
        flags.lateFlag[i] <= 1'b1;
        armed[i]          <= flags.lateSetSeen[i];
      end else if (flags.cmdValid && flags.lateFlag[i]) begin
        if (armed[i]) begin
          flags.lateFlag[i] <= 1'b0;
        end else begin
          armed[i] <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- csw_top.sv ----
// card status word: keeps and assembles the 32-bit status of the card
//
// Operation
// R1: keep a 32-bit status word, returned in every short response.
// R2: previous-command bits clear once a later valid command arrives.
// R3: condition bits mirror the card; clear-on-read bits clear after readout.
// R4: host polls status for bits found during execution.
// R5: bit 31 flags an argument arg_range_fault, clear on read.
// R6: bit 30 flags a misaligned address, clear on read.
// R7: bit 28 flags erase commands in wrong order, clear on read.
// R8: bit 27 flags an invalid erase selection, clear on read.
// R9: bit 26 flags a write to a protected block, clear on read.
// R10: bit 25 shows whether the locked_flag.
// R11: bit 24 flags lock command failure or locked access, clear on read.
// R12: bit 23 flags a failed command check, clears one command later.
// R13: bit 22 flags an illegal command, clears one command later.
// R14: bit 21 flags uncorrectable data, clear on read.
// R15: bits 20 and 19 flag controller and general faults, clear on read.
// R16: bit 18 flags stream read underrun, clear on read.
// R17: bit 17 flags stream write overrun, clear on read.
// R18: bit 16 flags identity or configuration rewrite faults.
// R19: bit 15 flags erase that skipped protected blocks, clear on read.
// R20: bit 14 shows whether error correction was disabled.
// R21: bit 13 flags an abandoned erase sequence, clear on read.
// R22: bits 12 to 9 carry the current card state code.
// R23: bit 8 follows the buffer-empty signalling.
// R24: bit 5 flags an expected or interpreted application command.
// R25: reserved bits read zero; bit 29 flags an unaccepted block length.
`timescale 1ns/100ps
module csw_top (
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  // command handling
  input  wire logic                        cmdValid,
  input  wire logic                        cmdCrcFail,
  input  wire logic                        cmdIllegal,
  input  wire logic                        statusRead,
  // fault events
  input  wire logic                        argRangeFault,
  input  wire logic                        misalignFault,
  input  wire logic                        blkLengthFault,
  input  wire logic                        eraseOrderFault,
  input  wire logic                        eraseSelectionFault,
  input  wire logic                        protectedWriteFault,
  input  wire logic                        lockSeqFault,
  input  wire logic                        lockedAccess,
  input  wire logic                        eccUncorrectable,
  input  wire logic                        controllerFault,
  input  wire logic                        generalFault,
  input  wire logic                        streamReadUnderrun,
  input  wire logic                        streamWriteOverrun,
  input  wire logic                        identRewrite,
  input  wire logic                        configMismatch,
  input  wire logic                        protectRevert,
  input  wire logic                        eraseSkip,
  input  wire logic                        eraseAbandon,
  input  wire logic                        appSpecificExpected,
  input  wire logic                        appSpecificCommand,
  // present conditions
  input  wire logic                        lockedFlag,
  input  wire logic                        eccDisabled,
  input  wire logic                        bufferEmpty,
  input  wire logic [csw_pkg::STATE_W-1:0] cardState,
  // results
  output logic      [csw_pkg::WORD_W-1:0]  statusWord,
  output logic                             anyError,
  output logic                             stateReserved
);

  // ----------------------------------------------------------------
  // internal signals
  // ----------------------------------------------------------------
  csw_flag_if flags ();

  logic                        lockedNow;
  logic                        eccOffNow;
  logic                        bufEmptyNow;
  logic [csw_pkg::STATE_W-1:0] stateNow;
  logic [csw_pkg::WORD_W-1:0]  next_statusWord;
  logic                        next_anyError;

  // true for the reserved state codes above disconnected
  function automatic logic isReserved(
    input logic [csw_pkg::STATE_W-1:0] code
  );
    isReserved = (code > csw_pkg::CSW_DIS);
  endfunction

  // ----------------------------------------------------------------
  // event routing into the clear-on-read flags
  // ----------------------------------------------------------------
  // R5: arg_range_fault argument
  assign flags.stickySet[csw_pkg::C_ARG_RANGE]    = argRangeFault;
  // R6: misaligned address
  assign flags.stickySet[csw_pkg::C_MISALIGN]     = misalignFault;
  // R25: unaccepted block length
  assign flags.stickySet[csw_pkg::C_BLK_LENGTH]   = blkLengthFault;
  // R7: erase order fault
  assign flags.stickySet[csw_pkg::C_ERASE_ORDER]  = eraseOrderFault;
  // R8: bad erase selection
  assign flags.stickySet[csw_pkg::C_ERASE_SELECT] = eraseSelectionFault;
  // R9: protected block write
  assign flags.stickySet[csw_pkg::C_PROT_WRITE]   = protectedWriteFault;
  // R11: lock failure or locked access
  assign flags.stickySet[csw_pkg::C_LOCK_FAIL]    = lockSeqFault
                                                  | lockedAccess;
  // R14: uncorrectable data
  assign flags.stickySet[csw_pkg::C_ECC_FAIL]     = eccUncorrectable;
  // R15: controller and general faults
  assign flags.stickySet[csw_pkg::C_CONTROLLER]   = controllerFault;
  assign flags.stickySet[csw_pkg::C_GENERAL]      = generalFault;
  // R16: stream read underrun
  assign flags.stickySet[csw_pkg::C_UNDERRUN]     = streamReadUnderrun;
  // R17: stream write overrun
  assign flags.stickySet[csw_pkg::C_OVERRUN]      = streamWriteOverrun;
  // R18: any of three rewrite faults
  assign flags.stickySet[csw_pkg::C_REWRITE]      = identRewrite
                                                  | configMismatch
                                                  | protectRevert;
  // R19: erase skipped protected blocks
  assign flags.stickySet[csw_pkg::C_ERASE_SKIP]   = eraseSkip;
  // R21: erase sequence abandoned
  assign flags.stickySet[csw_pkg::C_ERASE_ABORT]  = eraseAbandon;
  // R24: application command expected or taken
  assign flags.stickySet[csw_pkg::C_APP_EXPECT]   = appSpecificExpected
                                                  | appSpecificCommand;

  // R3: readout clears the sticky flags
  assign flags.readClear = statusRead;

  // ----------------------------------------------------------------
  // event routing into the one-command-late flags
  // ----------------------------------------------------------------
  // R12: failed check, shown by the next valid command
  assign flags.lateSet[csw_pkg::B_CMD_CHECK]     = cmdCrcFail;
  assign flags.lateSetSeen[csw_pkg::B_CMD_CHECK] = 1'b0;
  // R13: illegal command, shown in its own response
  assign flags.lateSet[csw_pkg::B_ILLEGAL]       = cmdIllegal;
  assign flags.lateSetSeen[csw_pkg::B_ILLEGAL]   = 1'b1;

  assign flags.cmdValid = cmdValid;

  // ----------------------------------------------------------------
  // flag keepers
  // ----------------------------------------------------------------
  csw_sticky_bits uSticky (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .flags   (flags)
  );

  csw_late_bits uLate (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .flags   (flags)
  );

  // ----------------------------------------------------------------
  // present-condition capture
  // ----------------------------------------------------------------
  // R3: condition bits track the card
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lockedNow   <= 1'b0;
      eccOffNow   <= 1'b0;
      bufEmptyNow <= 1'b0;
    end else begin
      lockedNow   <= lockedFlag;
      eccOffNow   <= eccDisabled;
      bufEmptyNow <= bufferEmpty;
    end
  end

  // R22: current state code capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateNow <= csw_pkg::CSW_IDLE;
    end else begin
      stateNow <= cardState;
    end
  end

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  // R25: untouched positions stay zero
  always_comb begin
    next_statusWord = csw_pkg::WORD_RST;
    for (int i = 0; i < csw_pkg::STICKY_N; i++) begin
      next_statusWord[csw_pkg::C_POS[i]] = flags.stickyFlag[i];
    end
    // R2: previous-command bits
    for (int j = 0; j < csw_pkg::LATE_N; j++) begin
      next_statusWord[csw_pkg::B_POS[j]] = flags.lateFlag[j];
    end
    // R10: lock state
    next_statusWord[csw_pkg::POS_LOCKED]    = lockedNow;
    // R20: correction disabled
    next_statusWord[csw_pkg::POS_ECC_OFF]   = eccOffNow;
    // R23: buffer empty
    next_statusWord[csw_pkg::POS_BUF_EMPTY] = bufEmptyNow;
    // R22: state field
    next_statusWord[csw_pkg::POS_STATE_LO +: csw_pkg::STATE_W] = stateNow;
  end

  // summary of every error bit
  assign next_anyError = |next_statusWord[csw_pkg::WORD_W-1:
                                          csw_pkg::POS_ERR_LO];

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // R1: word held for the response framer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      statusWord <= csw_pkg::WORD_RST;
      anyError   <= 1'b0;
    end else begin
      statusWord <= next_statusWord;
      anyError   <= next_anyError;
    end
  end

  // reserved state code seen
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stateReserved <= 1'b0;
    end else begin
      stateReserved <= isReserved(stateNow);
    end
  end

endmodule

// ---- csw_status_monitor.sv ----
// assertions watching the status word top ports
`timescale 1ns/100ps
module csw_status_monitor (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        cmdValid,
  input wire logic        cmdCrcFail,
  input wire logic        cmdIllegal,
  input wire logic        statusRead,
  input wire logic        argRangeFault,
  input wire logic        lockedFlag,
  input wire logic        eccDisabled,
  input wire logic        bufferEmpty,
  input wire logic [3:0]  cardState,
  input wire logic [31:0] statusWord,
  input wire logic        anyError,
  input wire logic        stateReserved
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  logic [1:0] upCnt;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // edges since reset, so two-deep history is valid
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  a_arg_range_set: assert property (
    argRangeFault |-> ##2 statusWord[31])
    else $error("argument range flag not shown");
  a_arg_read_clear: assert property (
    statusRead && !argRangeFault |-> ##2 !statusWord[31])
    else $error("argument range flag not cleared by read");
  a_illegal_set: assert property (
    cmdValid && cmdIllegal |-> ##2 statusWord[22])
    else $error("illegal command flag not shown");
  a_illegal_late_clear: assert property (
    cmdValid && !cmdIllegal && statusWord[22] |-> ##2 !statusWord[22])
    else $error("illegal command flag not cleared");
  a_check_fail_set: assert property (
    cmdCrcFail |-> ##2 statusWord[23])
    else $error("command check flag not shown");
  a_level_bits: assert property (
    upCnt == 2'h3 |-> statusWord[25] == $past(lockedFlag, 2) &&
      statusWord[14] == $past(eccDisabled, 2) &&
      statusWord[8] == $past(bufferEmpty, 2))
    else $error("level bits do not follow inputs");
  a_state_track: assert property (
    upCnt == 2'h3 |-> statusWord[12:9] == $past(cardState, 2))
    else $error("state field does not follow state");
  a_state_reserved: assert property (
    upCnt == 2'h3 |-> stateReserved == ($past(cardState, 2) > 4'h8))
    else $error("reserved state report wrong");
  a_reserved_zero: assert property (
    statusWord[7:6] == 2'h0 && statusWord[4:0] == 5'h0)
    else $error("reserved bits not zero");
  a_any_error: assert property (
    anyError == (|statusWord[31:16]))
    else $error("error summary mismatch");
endmodule

bind csw_top csw_status_monitor i_csw_status_monitor (
  .clk_sys, .arst_n, .cmdValid, .cmdCrcFail, .cmdIllegal, .statusRead,
  .argRangeFault, .lockedFlag, .eccDisabled, .bufferEmpty, .cardState,
  .statusWord, .anyError, .stateReserved);

// ---- csw_host_model.sv ----
// host side command model: turns bench requests into command pulses
`timescale 1ns/100ps
module csw_host_model (
  input wire logic [1:0] reqCode,
  input wire logic       reqGo,
  output logic           cmdValid,
  output logic           cmdCrcFail,
  output logic           cmdIllegal,
  output logic           statusRead
);
  // 0 valid, 1 illegal, 2 failed check, 3 status poll
  always_comb begin
    cmdValid = reqGo && !reqCode[1];
    cmdIllegal = reqGo && reqCode == 2'h1;
    cmdCrcFail = reqGo && reqCode == 2'h2;
    statusRead = reqGo && reqCode == 2'h3;
  end
endmodule

// ---- card_status_word_tb.sv ----
// self-checking bench for the card status word
`timescale 1ns/100ps
module card_status_word_tb;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [19:0] ev = 20'h0;
  logic [1:0]  reqCode = 2'h0;
  logic        reqGo = 1'b0;
  logic        cmdValid, cmdCrcFail, cmdIllegal, statusRead;
  logic        lockedFlag = 1'b0;
  logic        eccDisabled = 1'b0;
  logic        bufferEmpty = 1'b0;
  logic [3:0]  cardState = 4'h0;
  logic [31:0] statusWord, exp;
  logic        anyError, stateReserved;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          posTab [20] = '{31, 30, 29, 28, 27, 26, 24, 24, 21, 20,
                               19, 18, 17, 16, 16, 16, 15, 13, 5, 5};

  // free-running 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  csw_host_model i_csw_host_model (
    .reqCode, .reqGo, .cmdValid, .cmdCrcFail, .cmdIllegal, .statusRead);

  csw_top i_csw_top (
    .clk_sys, .arst_n, .cmdValid, .cmdCrcFail, .cmdIllegal, .statusRead,
    .argRangeFault(ev[0]), .misalignFault(ev[1]), .blkLengthFault(ev[2]),
    .eraseOrderFault(ev[3]), .eraseSelectionFault(ev[4]),
    .protectedWriteFault(ev[5]), .lockSeqFault(ev[6]),
    .lockedAccess(ev[7]), .eccUncorrectable(ev[8]),
    .controllerFault(ev[9]), .generalFault(ev[10]),
    .streamReadUnderrun(ev[11]), .streamWriteOverrun(ev[12]),
    .identRewrite(ev[13]), .configMismatch(ev[14]),
    .protectRevert(ev[15]), .eraseSkip(ev[16]), .eraseAbandon(ev[17]),
    .appSpecificExpected(ev[18]), .appSpecificCommand(ev[19]),
    .lockedFlag, .eccDisabled, .bufferEmpty, .cardState,
    .statusWord, .anyError, .stateReserved);

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] got, e);
    cmp_count++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, got);
    end
  endtask

  // one request, returns once the word shows its effect
  task automatic host(input logic [1:0] c);
    reqCode = c;
    reqGo = 1'b1;
    step(1);
    reqGo = 1'b0;
    step(1);
  endtask

  task automatic fire(input int i);
    ev[i] = 1'b1;
    step(1);
    ev[i] = 1'b0;
    step(1);
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  initial begin
    step(16);
    arst_n = 1'b1;
    chk("reset", statusWord, 32'h0);
    // every event flag, then cleared by a status poll
    for (int i = 0; i < 20; i++) begin
      fire(i);
      exp = 32'h1 << posTab[i];
      chk("set", statusWord, exp);
      chk("err", anyError, 32'(posTab[i] >= 16));
      host(2'h3);
      chk("clear", statusWord, 32'h0);
    end
    // set wins over a simultaneous read
    ev[0] = 1'b1;
    reqCode = 2'h3;
    reqGo = 1'b1;
    step(1);
    ev[0] = 1'b0;
    reqGo = 1'b0;
    step(1);
    chk("setwin", statusWord, 32'h8000_0000);
    host(2'h3);
    // illegal flag cleared by the next valid command
    host(2'h1);
    chk("ill", statusWord[22], 32'h1);
    host(2'h0);
    chk("illclr", statusWord[22], 32'h0);
    // check failure survives one valid command, not two
    host(2'h2);
    chk("crc", statusWord[23], 32'h1);
    host(2'h0);
    chk("crc1", statusWord[23], 32'h1);
    host(2'h0);
    chk("crc2", statusWord[23], 32'h0);
    // condition bits and every state code
    lockedFlag = 1'b1;
    eccDisabled = 1'b1;
    bufferEmpty = 1'b1;
    for (int s = 0; s < 16; s++) begin
      cardState = 4'(s);
      step(2);
      exp = 32'h0200_4100 | (32'(s) << 9);
      chk("level", statusWord, exp);
      step(1);
      chk("rsvd", stateReserved, 32'(s > 8));
    end
    lockedFlag = 1'b0;
    eccDisabled = 1'b0;
    bufferEmpty = 1'b0;
    cardState = 4'h0;
    // second reset with a flag pending
    fire(0);
    arst_n = 1'b0;
    step(1);
    chk("rst2", statusWord, 32'h0);
    arst_n = 1'b1;
    step(3);
    chk("after", statusWord, 32'h0);
    results();
  end
endmodule
